// [design/tps_pkg.sv]
// constants and types of the transmit process-data scheduler
package tps_pkg;
  localparam int              CHANNELS      = 4;
  localparam int              ENTRIES       = 4;
  localparam int              CLK_PERIOD_NS = 40;
  localparam int              MS_NS         = 1000000;
  localparam int              MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  // word index inside one channel window of 0x40 bytes
  localparam logic [3:0]      F_COUNT       = 4'h0;
  localparam logic [3:0]      F_IDENT       = 4'h1;
  localparam logic [3:0]      F_TYPE        = 4'h2;
  localparam logic [3:0]      F_GAP         = 4'h3;
  localparam logic [3:0]      F_LEGACY      = 4'h4;
  localparam logic [3:0]      F_PERIOD      = 4'h5;
  localparam logic [3:0]      F_MAPCNT      = 4'h8;
  localparam logic [3:0]      F_MAP_FIRST   = 4'h9;
  localparam logic [3:0]      F_MAP_LAST    = 4'hc;
  localparam logic [8:0]      A_NODE        = 9'h100;
  localparam logic [8:0]      A_STATUS      = 9'h104;
  localparam int              ID_EXISTS_BIT = 31;
  localparam int              ID_NORTR_BIT  = 26;
  localparam logic [31:0]     ID_ON_FLAGS   = 32'h4000_0000;
  localparam logic [31:0]     ID_OFF_FLAGS  = 32'hc000_0000;
  localparam logic [7:0]      ENTRY_COUNT   = 8'h05;
  localparam logic [7:0]      SEND_TYPE     = 8'hfe;
  localparam logic [15:0]     PERIOD_CH1_MS = 16'h0064;
  localparam logic [6:0]      NODE_RST      = 7'h01;
  localparam logic [3:0]      MAX_DLC       = 4'h8;
  localparam logic [3:0][10:0] ID_BASE      = {11'h480, 11'h380,
                                               11'h280, 11'h180};
  localparam logic [3:0][15:0] PERIOD_RST   = {16'h0000, 16'h0000,
                                               16'h0000, PERIOD_CH1_MS};
  localparam logic [3:0][7:0] MAPCNT_RST    = {8'h02, 8'h02, 8'h02, 8'h03};
  localparam logic [3:0][3:0][31:0] MAP_RST = {
    {32'h0000_0000, 32'h0000_0000, 32'h5030_0020, 32'h5020_0020},
    {32'h0000_0000, 32'h0000_0000, 32'h2460_0210, 32'h2460_0110},
    {32'h0000_0000, 32'h0000_0000, 32'h7330_0210, 32'h7330_0110},
    {32'h0000_0000, 32'h2370_0210, 32'h2370_0110, 32'h7100_0110}};
  typedef enum logic [1:0] {
    TPS_IDLE  = 2'b00,
    TPS_FETCH = 2'b01,
    TPS_SEND  = 2'b11
  } tps_state_e;
endpackage

// [design/tps_sched.sv]
// transmit process-data scheduler with wishbone record access
// Overview of operation
// - four transmit channels, 11-bit base identifiers, never answer remote requests
// - each existing channel with a non-zero mapping count sends a frame whenever its event timer expires
// - after reset only channel one exists; flags 40000000h or C0000000h plus id
// - identifier bases 180h, 280h, 380h plus node number
// - a node number change recomputes every identifier from base and node
// - exists bit 80000000h set means channel destroyed and never sent
// - flag 04000000h means remote requests are not allowed
// - event timer resets to 100 ms on channel one, 0 elsewhere, writable
// - zero period never sends; only non-zero periods run when operational
// - transmission type reads 254 for every channel and is read-only
// - mapping count at index 0, entries 1 to 4, unused entries zero
// - channel one maps analog input one and both output feedback values
// - channel two maps the field values of analog outputs one and two
// - channel three maps the two controller output field values
// - channel four base 480h maps supply and temperature, 32 bits each
`timescale 1ns/1ps
`default_nettype none
module tps_sched #(
  parameter int         TICK_CYCLES = tps_pkg::MS_CYCLES,
  parameter logic [6:0] NODE_RESET  = tps_pkg::NODE_RST
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [8:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        oper_i,
  input  wire logic [6:0]  node_id_i,
  input  wire logic        node_load_i,
  output logic             obj_req_o,
  output logic      [15:0] obj_index_o,
  output logic      [7:0]  obj_sub_o,
  input  wire logic [31:0] obj_data_i,
  output logic             tx_valid_o,
  output logic      [10:0] tx_id_o,
  output logic      [3:0]  tx_dlc_o,
  output logic      [63:0] tx_data_o,
  input  wire logic        tx_ready_i
);
  typedef struct packed {
    logic [3:0][31:0]      ident;
    logic [3:0][15:0]      gap;
    logic [3:0][7:0]       legacy;
    logic [3:0][15:0]      period;
    logic [3:0][7:0]       mapcnt;
    logic [3:0][3:0][31:0] map;
    logic [3:0][15:0]      timer;
    logic [3:0]            pend;
    logic [6:0]            node;
    logic [15:0]           tick;
    tps_pkg::tps_state_e   state;
    logic [1:0]            ch;
    logic [1:0]            ent;
    logic [3:0]            nbytes;
    logic [15:0]           sent;
    logic                  ack;
    logic [31:0]           rdat;
    logic                  obj_req;
    logic [15:0]           obj_index;
    logic [7:0]            obj_sub;
    logic                  tx_valid;
    logic [10:0]           tx_id;
    logic [3:0]            tx_dlc;
    logic [63:0]           tx_data;
  } tps_regs_s;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  tps_regs_s   s;
  tps_regs_s   next_s;
  logic        req;
  logic [1:0]  chsel;
  logic [3:0]  fld;
  logic [1:0]  msel;
  logic        tick_hit;
  logic [3:0]  live;
  logic [3:0]  set_p;
  logic [3:0]  clr_p;
  logic [6:0]  new_node;
  logic        do_node;
  logic [7:0]  len;
  logic [4:0]  sum;
  logic [3:0]  cnt_sat;
  logic        last;

  function automatic logic [31:0] tps_merge(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [10:0] tps_ident(input int c,
                                            input logic [6:0] node);
    return 11'(tps_pkg::ID_BASE[c] + {4'h0, node});
  endfunction

  // object lands at byte pos; bytes past the eighth fall off the frame
  function automatic logic [63:0] tps_place(input logic [63:0] acc,
                                            input logic [3:0]  pos,
                                            input logic [31:0] data,
                                            input logic [7:0]  bits);
    logic [31:0] mask;
    logic [63:0] wide;
    mask = (bits >= 8'h20) ? 32'hffff_ffff :
           ((32'h0000_0001 << bits[4:0]) - 32'h0000_0001);
    wide = {32'h0000_0000, data & mask};
    if (pos >= tps_pkg::MAX_DLC) begin
      return acc;
    end
    return acc | (wide << {pos[2:0], 3'b000});
  endfunction

  function automatic tps_regs_s tps_reset(input logic [6:0] node);
    tps_regs_s r;
    r = '0;
    r.node = node;
    r.state = tps_pkg::TPS_IDLE;
    for (int c = 0; c < tps_pkg::CHANNELS; c++) begin
      r.ident[c] = ((c == 0) ? tps_pkg::ID_ON_FLAGS : tps_pkg::ID_OFF_FLAGS)
                   | {21'h000000, tps_ident(c, node)};
      r.period[c] = tps_pkg::PERIOD_RST[c];
      r.timer[c] = tps_pkg::PERIOD_RST[c];
      r.mapcnt[c] = tps_pkg::MAPCNT_RST[c];
      r.map[c] = tps_pkg::MAP_RST[c];
    end
    return r;
  endfunction

  always_comb begin
    next_s = s;
    req = wb_cyc_i && wb_stb_i && !s.ack;
    chsel = wb_adr_i[7:6];
    fld = wb_adr_i[5:2];
    msel = 2'(fld - tps_pkg::F_MAP_FIRST);
    next_s.ack = req;
    next_s.rdat = 32'h0000_0000;
    new_node = s.node;
    do_node = 1'b0;
    set_p = 4'h0;
    clr_p = 4'h0;
    len = 8'h00;
    sum = 5'h00;
    cnt_sat = 4'h0;
    last = 1'b0;
    // unmapped words read zero and swallow writes, but are still acked
    if (req && !wb_adr_i[8]) begin
      case (fld)
        tps_pkg::F_COUNT: begin
          next_s.rdat = {24'h000000, tps_pkg::ENTRY_COUNT};
        end
        tps_pkg::F_IDENT: begin
          // no-remote flag is only stored; no remote path exists
          next_s.rdat = s.ident[chsel];
          if (wb_we_i) begin
            next_s.ident[chsel] = tps_merge(s.ident[chsel], wb_dat_i, wb_sel_i);
          end
        end
        tps_pkg::F_TYPE: begin
          next_s.rdat = {24'h000000, tps_pkg::SEND_TYPE};
        end
        tps_pkg::F_GAP: begin
          next_s.rdat = {16'h0000, s.gap[chsel]};
          if (wb_we_i) begin
            next_s.gap[chsel] = 16'(tps_merge({16'h0000, s.gap[chsel]},
                                              wb_dat_i, wb_sel_i));
          end
        end
        tps_pkg::F_LEGACY: begin
          next_s.rdat = {24'h000000, s.legacy[chsel]};
          if (wb_we_i) begin
            next_s.legacy[chsel] = 8'(tps_merge({24'h000000, s.legacy[chsel]},
                                                wb_dat_i, wb_sel_i));
          end
        end
        tps_pkg::F_PERIOD: begin
          next_s.rdat = {16'h0000, s.period[chsel]};
          if (wb_we_i) begin
            next_s.period[chsel] = 16'(tps_merge({16'h0000, s.period[chsel]},
                                                 wb_dat_i, wb_sel_i));
          end
        end
        tps_pkg::F_MAPCNT: begin
          next_s.rdat = {24'h000000, s.mapcnt[chsel]};
          if (wb_we_i) begin
            next_s.mapcnt[chsel] = 8'(tps_merge({24'h000000, s.mapcnt[chsel]},
                                                wb_dat_i, wb_sel_i));
          end
        end
        default: begin
          if (fld >= tps_pkg::F_MAP_FIRST && fld <= tps_pkg::F_MAP_LAST) begin
            next_s.rdat = s.map[chsel][msel];
            if (wb_we_i) begin
              next_s.map[chsel][msel] = tps_merge(s.map[chsel][msel],
                                                  wb_dat_i, wb_sel_i);
            end
          end
        end
      endcase
    end else if (req && wb_adr_i == tps_pkg::A_NODE) begin
      next_s.rdat = {25'h0000000, s.node};
      if (wb_we_i && wb_sel_i[0]) begin
        new_node = wb_dat_i[6:0];
        do_node = 1'b1;
      end
    end else if (req && wb_adr_i == tps_pkg::A_STATUS) begin
      next_s.rdat = {s.sent, 8'h00, 2'b00, s.state, s.pend};
    end
    // layer-setting load beats a bus write in the same cycle
    if (node_load_i) begin
      new_node = node_id_i;
      do_node = 1'b1;
    end
    if (do_node) begin
      next_s.node = new_node;
      for (int c = 0; c < tps_pkg::CHANNELS; c++) begin
        next_s.ident[c][10:0] = tps_ident(c, new_node);
      end
    end

    // millisecond base shared by all event timers
    tick_hit = (s.tick == TICK_LAST);
    next_s.tick = tick_hit ? 16'h0000 : 16'(s.tick + 16'h0001);
    for (int c = 0; c < tps_pkg::CHANNELS; c++) begin
      live[c] = oper_i && !s.ident[c][tps_pkg::ID_EXISTS_BIT]
                && (s.period[c] != 16'h0000);
      if (!live[c]) begin
        next_s.timer[c] = s.period[c]; // first frame one full period in
      end else if (tick_hit) begin
        if (s.timer[c] <= 16'h0001) begin
          next_s.timer[c] = s.period[c];
          set_p[c] = 1'b1;
        end else begin
          next_s.timer[c] = 16'(s.timer[c] - 16'h0001);
        end
      end
    end

    case (s.state)
      tps_pkg::TPS_IDLE: begin
        for (int c = tps_pkg::CHANNELS - 1; c >= 0; c--) begin
          if (s.pend[c]) begin
            next_s.ch = 2'(c);
          end
        end
        if (|s.pend) begin
          clr_p[next_s.ch] = 1'b1;
          next_s.ent = 2'b00;
          next_s.nbytes = 4'h0;
          next_s.tx_data = 64'h0000_0000_0000_0000;
          // an empty mapping (mid-remap) drops the frame
          if (s.mapcnt[next_s.ch] != 8'h00) begin
            next_s.obj_req = 1'b1;
            next_s.obj_index = s.map[next_s.ch][0][31:16];
            next_s.obj_sub = s.map[next_s.ch][0][15:8];
            next_s.state = tps_pkg::TPS_FETCH;
          end
        end
      end
      tps_pkg::TPS_FETCH: begin
        len = s.map[s.ch][s.ent][7:0];
        next_s.tx_data = tps_place(s.tx_data, s.nbytes, obj_data_i, len);
        sum = 5'({1'b0, s.nbytes} + {1'b0, len[6:3]});
        cnt_sat = (sum > 5'h08) ? tps_pkg::MAX_DLC : sum[3:0];
        next_s.nbytes = cnt_sat;
        last = (s.ent == 2'b11) ||
               (8'({6'h00, s.ent} + 8'h01) >= s.mapcnt[s.ch]);
        if (last) begin
          next_s.obj_req = 1'b0;
          next_s.tx_valid = 1'b1;
          next_s.tx_id = s.ident[s.ch][10:0];
          next_s.tx_dlc = cnt_sat;
          next_s.state = tps_pkg::TPS_SEND;
        end else begin
          next_s.ent = 2'(s.ent + 2'b01);
          next_s.obj_index = s.map[s.ch][next_s.ent][31:16];
          next_s.obj_sub = s.map[s.ch][next_s.ent][15:8];
        end
      end
      tps_pkg::TPS_SEND: begin
        if (tx_ready_i) begin
          next_s.tx_valid = 1'b0;
          next_s.sent = 16'(s.sent + 16'h0001);
          next_s.state = tps_pkg::TPS_IDLE;
        end
      end
      default: begin
        next_s.state = tps_pkg::TPS_IDLE;
      end
    endcase
    // timer set wins over the scheduler's clear
    next_s.pend = (s.pend & ~clr_p & live) | set_p;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= tps_reset(NODE_RESET);
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o    = s.ack;
  assign wb_dat_o    = s.rdat;
  assign obj_req_o   = s.obj_req;
  assign obj_index_o = s.obj_index;
  assign obj_sub_o   = s.obj_sub;
  assign tx_valid_o  = s.tx_valid;
  assign tx_id_o     = s.tx_id;
  assign tx_dlc_o    = s.tx_dlc;
  assign tx_data_o   = s.tx_data;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_hold;
    tx_valid_o && !tx_ready_i;
  endsequence

  property p_wb_ack;
    s_req |=> s_ack_pulse;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack not one pulse");

  property p_type_ro;
    (s_req ##0 (!wb_adr_i[8] && wb_adr_i[5:2] == tps_pkg::F_TYPE))
      |=> (wb_dat_o == 32'h0000_00fe);
  endproperty
  a_type_ro: assert property (p_type_ro) else $error("type not 254");

  property p_reset_vals;
    $fell(rst_i) |-> (s.period[0] == 16'h0064) && (s.period[1] == 16'h0000)
      && (s.mapcnt[0] == 8'h03) && s.ident[1][31] && !s.ident[0][31];
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset");

  property p_node_load;
    node_load_i |=> (s.ident[1][10:0] == 11'(11'h280 + {4'h0, $past(node_id_i)}));
  endproperty
  a_node_load: assert property (p_node_load) else $error("id not rebuilt");

  property p_pend_exists;
    s.pend[0] |-> $past(!s.ident[0][31] && oper_i);
  endproperty
  a_pend_exists: assert property (p_pend_exists) else $error("dead pending");

  property p_zero_period;
    $rose(s.pend[1]) |-> $past(s.period[1]) != 16'h0000;
  endproperty
  a_zero_period: assert property (p_zero_period) else $error("zero sends");

  property p_reload;
    $rose(s.pend[0]) |-> (s.timer[0] == $past(s.period[0]));
  endproperty
  a_reload: assert property (p_reload) else $error("timer not reloaded");

  property p_tx_hold;
    s_hold |=> tx_valid_o && $stable(tx_id_o) && $stable(tx_data_o)
               && $stable(tx_dlc_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("frame changed");

  property p_dlc;
    tx_valid_o |-> (tx_dlc_o <= 4'h8) && !obj_req_o;
  endproperty
  a_dlc: assert property (p_dlc) else $error("dlc above eight");

  property p_entry;
    obj_req_o |-> (s.state == tps_pkg::TPS_FETCH)
      && (obj_sub_o == s.map[s.ch][s.ent][15:8]);
  endproperty
  a_entry: assert property (p_entry) else $error("wrong entry");
endmodule
`default_nettype wire

// [dv/tps_can_peer.sv]
// object source and frame receiver at the scheduler's far side
`timescale 1ns/1ps
`default_nettype none
module tps_can_peer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        obj_req_i,
  input  wire logic [15:0] obj_index_i,
  input  wire logic [7:0]  obj_sub_i,
  output logic      [31:0] obj_data_o,
  input  wire logic        tx_valid_i,
  input  wire logic [10:0] tx_id_i,
  input  wire logic [3:0]  tx_dlc_i,
  input  wire logic [63:0] tx_data_i,
  output logic             tx_ready_o,
  input  wire logic [3:0]  stall_i,
  output logic      [15:0] frames_o,
  output logic      [10:0] last_id_o,
  output logic      [3:0]  last_dlc_o,
  output logic      [63:0] last_data_o
);
  logic [3:0]  wait_cnt;
  logic [31:0] noise;
  // outside a fetch the value flips each cycle so a late sample shows
  assign obj_data_o = obj_req_i ?
    {obj_index_i ^ 16'h5a5a, obj_sub_i, obj_sub_i ^ 8'hc3} : noise;
  // slow acceptance: hold off stall_i cycles per frame
  assign tx_ready_o = tx_valid_i && (wait_cnt >= stall_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      noise       <= 32'h3c3c_a5a5;
      wait_cnt    <= 4'h0;
      frames_o    <= 16'h0;
      last_id_o   <= 11'h0;
      last_dlc_o  <= 4'h0;
      last_data_o <= 64'h0;
    end else begin
      noise <= ~noise;
      if (tx_valid_i && tx_ready_o) begin
        wait_cnt    <= 4'h0;
        frames_o    <= frames_o + 16'h1;
        last_id_o   <= tx_id_i;
        last_dlc_o  <= tx_dlc_i;
        last_data_o <= tx_data_i;
      end else if (tx_valid_i) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/tb.sv]
// self-checking bench for the transmit process-data scheduler
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, oper, node_load;
  logic obj_req, tx_valid, tx_ready;
  logic [8:0]  wb_adr;
  logic [31:0] wb_wdat, wb_rdat, obj_data, rd, idv;
  logic [3:0]  wb_sel, tx_dlc, stall, last_dlc;
  logic [6:0]  node_id;
  logic [15:0] obj_index, frames, seen;
  logic [7:0]  obj_sub;
  logic [10:0] tx_id, last_id;
  logic [63:0] tx_data, last_data, pay;
  int          errors = 0;
  int          check_count = 0;
  int          took;
  // 4 clocks per ms keeps a 100 ms period at 400 cycles
  tps_sched #(.TICK_CYCLES(4), .NODE_RESET(tps_pkg::NODE_RST)) i_tps_sched (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .oper_i(oper), .node_id_i(node_id),
    .node_load_i(node_load), .obj_req_o(obj_req), .obj_index_o(obj_index),
    .obj_sub_o(obj_sub), .obj_data_i(obj_data), .tx_valid_o(tx_valid),
    .tx_id_o(tx_id), .tx_dlc_o(tx_dlc), .tx_data_o(tx_data),
    .tx_ready_i(tx_ready));
  tps_can_peer i_tps_can_peer (
    .clk_i(clk_i), .rst_i(rst_i), .obj_req_i(obj_req),
    .obj_index_i(obj_index), .obj_sub_i(obj_sub), .obj_data_o(obj_data),
    .tx_valid_i(tx_valid), .tx_id_i(tx_id), .tx_dlc_i(tx_dlc),
    .tx_data_i(tx_data), .tx_ready_o(tx_ready), .stall_i(stall),
    .frames_o(frames), .last_id_o(last_id), .last_dlc_o(last_dlc),
    .last_data_o(last_data));
  function automatic logic [31:0] objv(input logic [15:0] i,
                                       input logic [7:0]  s);
    return {i ^ 16'h5a5a, s, s ^ 8'hc3};
  endfunction
  task automatic check(input string what, input logic [63:0] got,
                       input logic [63:0] expv);
    check_count++;
    if (got !== expv) begin
      errors++;
      $display("Error %s expected %h seen %h", what, expv, got);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [8:0] a,
                    input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= wd;
    @(posedge clk_i);
    while (wb_ack !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
    check("bus answer", 64'(n < 16), 64'h1);
  endtask
  task automatic rdchk(input string what, input logic [8:0] a,
                       input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(what, 64'(rd), 64'(e));
  endtask
  task automatic wait_frame(input int maxc);
    logic [15:0] f0;
    f0 = frames;
    took = 0;
    while (frames === f0 && took < maxc) begin
      @(posedge clk_i);
      took++;
    end
    check("frame arrives", 64'(took < maxc), 64'h1);
  endtask
  task automatic frame_chk(input logic [10:0] id, input logic [3:0] dlc,
                           input logic [63:0] p, input logic [63:0] m);
    check("frame id", 64'(last_id), 64'(id));
    check("frame dlc", 64'(last_dlc), 64'(dlc));
    check("frame data", last_data & m, p);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    check("watchdog", 64'h1, 64'h0);
    close_out();
  end
  initial begin
    {wb_cyc, wb_stb, wb_we, oper, node_load} = 5'h00;
    {wb_adr, wb_wdat, node_id, stall} = '0;
    wb_sel = 4'hf;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int c = 0; c < 4; c++) begin
      idv = (c == 0) ? tps_pkg::ID_ON_FLAGS : tps_pkg::ID_OFF_FLAGS;
      idv = idv + 32'(tps_pkg::ID_BASE[c]) + 32'(tps_pkg::NODE_RST);
      for (int f = 0; f < 13; f++) begin
        case (f)
          0: rdchk("entry count", 9'(c * 64), 32'h5);
          1: rdchk("ident", 9'(c * 64 + 4), idv);
          2: rdchk("type", 9'(c * 64 + 8), 32'hfe);
          5: rdchk("period", 9'(c * 64 + 20), (c == 0) ? 32'h64 : 32'h0);
          8: rdchk("map count", 9'(c * 64 + 32), 32'(tps_pkg::MAPCNT_RST[c]));
          9, 10, 11, 12: rdchk("map entry", 9'(c * 64 + f * 4),
                               tps_pkg::MAP_RST[c][f - 9]);
          default: rdchk("unused word", 9'(c * 64 + f * 4), 32'h0);
        endcase
      end
    end
    wb(1'b1, 9'h008, 32'h0);
    rdchk("type kept", 9'h008, 32'hfe);
    wb(1'b1, 9'h000, 32'h0);
    rdchk("count kept", 9'h000, 32'h5);
    wb(1'b1, 9'h08c, 32'h1234);
    rdchk("gap", 9'h08c, 32'h1234);
    wb(1'b1, 9'h090, 32'ha5);
    rdchk("legacy", 9'h090, 32'ha5);
    wb(1'b1, 9'h0d4, 32'h3);
    rdchk("period rw", 9'h0d4, 32'h3);
    wb(1'b1, 9'h0d4, 32'h0);
    wb(1'b1, 9'h1f0, 32'hffff_ffff);
    rdchk("unmapped", 9'h1f0, 32'h0);
    repeat (300) @(posedge clk_i);
    check("idle frames", 64'(frames), 64'h0);
    oper <= 1'b1;
    wait_frame(450);
    check("first gap", 64'(took >= 398 && took <= 420), 64'h1);
    pay = {16'h0, 16'(objv(16'h2370, 8'h02)), 16'(objv(16'h2370, 8'h01)),
           16'(objv(16'h7100, 8'h01))};
    frame_chk(11'h181, 4'h6, pay, 64'h0000_ffff_ffff_ffff);
    wait_frame(450);
    check("period gap", 64'(took >= 395 && took <= 405), 64'h1);
    check("frame count", 64'(frames), 64'h2);
    node_id <= 7'h05;
    node_load <= 1'b1;
    @(posedge clk_i);
    node_load <= 1'b0;
    @(posedge clk_i);
    for (int c = 0; c < 4; c++) begin
      idv = (c == 0) ? tps_pkg::ID_ON_FLAGS : tps_pkg::ID_OFF_FLAGS;
      rdchk("new ident", 9'(c * 64 + 4), idv + 32'(tps_pkg::ID_BASE[c]) + 32'h5);
    end
    rdchk("node reg", 9'h100, 32'h5);
    wait_frame(450);
    frame_chk(11'h185, 4'h6, pay, 64'h0000_ffff_ffff_ffff);
    wb(1'b1, 9'h014, 32'h0);
    wb(1'b1, 9'h044, 32'hc000_0285);
    wb(1'b1, 9'h054, 32'h2);
    stall <= 4'h3;
    seen = frames;
    repeat (40) @(posedge clk_i);
    check("destroyed quiet", 64'(frames), 64'(seen));
    wb(1'b1, 9'h060, 32'h0);
    wb(1'b1, 9'h064, 32'h5020_0020);
    wb(1'b1, 9'h068, 32'h7100_0108);
    wb(1'b1, 9'h060, 32'h2);
    wb(1'b1, 9'h044, 32'h4400_0285);
    rdchk("no remote flag", 9'h044, 32'h4400_0285);
    wait_frame(40);
    pay = {24'h0, 8'(objv(16'h7100, 8'h01)), objv(16'h5020, 8'h00)};
    frame_chk(11'h285, 4'h5, pay, 64'h0000_00ff_ffff_ffff);
    wait_frame(40);
    check("short gap", 64'(took >= 6 && took <= 12), 64'h1);
    wb(1'b1, 9'h054, 32'h0);
    repeat (20) @(posedge clk_i);
    seen = frames;
    repeat (100) @(posedge clk_i);
    check("zero period quiet", 64'(frames), 64'(seen));
    rdchk("status", 9'h104, {frames, 16'h0000});
    close_out();
  end
endmodule
`default_nettype wire
